// ==== rtl/rfc_defines.vh ====
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH

// ***************************************************
// Register offsets (6-bit register address space)
// ***************************************************
`define RFC_ADDR_FILT 6'h09
`define RFC_ADDR_MISC2 6'h0E
`define RFC_ADDR_STAT 6'h2C

// ***************************************************
// Field positions of the filter settings register
// ***************************************************
`define RFC_BASS_LSB 0
`define RFC_BASS_MSB 2
`define RFC_TREB_LSB 3
`define RFC_TREB_MSB 5
`define RFC_SKIP1_BIT 6
`define RFC_SKIP2_BIT 7

// ***************************************************
// Field positions of miscellaneous register 2
// ***************************************************
`define RFC_PAGE_LSB 4
`define RFC_PAGE_MSB 5
`define RFC_NUDGE_BIT 7

// ***************************************************
// Reset values and page codes
// ***************************************************
`define RFC_FILT_RST 8'hFF
`define RFC_MISC2_RST 8'h00
`define RFC_TRIM_RST 4'h8
`define RFC_PAGE_TRIM 2'h2

// ***************************************************
// Command codes
// ***************************************************
`define RFC_CMD_CAL 8'h88
`define RFC_CMD_DEC 8'h89
`define RFC_CMD_INC 8'h8A

// ***************************************************
// Timing
// ***************************************************
`define RFC_CLK_MHZ 250
`define RFC_CAL_MAX_US 5000
`define RFC_CAL_STEPS 8
`define RFC_CAL_STEP_CYC (`RFC_CAL_MAX_US * `RFC_CLK_MHZ / (`RFC_CAL_STEPS + 2))
`define RFC_AC_STEP_NS 400
`define RFC_AC_STEP_CYC (`RFC_AC_STEP_NS / 4)

`endif

// ==== rtl/rfc_rx_filter_ctrl.v ====
// Contract
// RULE1 - Command 88h starts the resistor/capacitor compensation sequence.
// RULE2 - Calibration completes within 5 ms of the command being accepted.
// RULE3 - Host calibrates after power-up, before reception, and after temperature shifts.
// RULE4 - Trim results readable as two 4-bit fields at 2Ch, page 10b.
// RULE5 - Commands 89h/8Ah decrement/increment trims only when trim_nudge_allow set.
// RULE6 - Bass trim moves high-pass corner, treble trim low-pass, 4% steps, +/-30%.
// RULE7 - Register 09h fields select high-pass and low-pass corner frequencies.
// RULE8 - Two stage-skip bits bypass filter stages for low link frequencies.
// RULE9 - Host generally programs filter register to FFh.
// RULE10 - Dense-reader M4/M8: 24h at 320 kHz, 34h at 250 kHz.
// RULE11 - Other modes: FFh at 40 kHz, BFh/3Fh at 160 kHz, 04h at 640 kHz.
// RULE12 - Filter codes map to link-frequency groups 640/320/250/160/40 kHz.
// RULE13 - AC coupling stores DC points before modulation, ramps time constant after.
// RULE14 - Old trims stay applied until calibration ends; host waits meanwhile.
`timescale 1ns/1ns
`default_nettype none
`include "rfc_defines.vh"

module rfc_rx_filter_ctrl #(
  parameter CAL_STEP_CYC = `RFC_CAL_STEP_CYC,
  parameter AC_STEP_CYC = `RFC_AC_STEP_CYC,
  parameter AC_STEPS = 4
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire cmd_valid_i,
  input wire [7:0] cmd_code_i,
  input wire cal_cmp_i,
  input wire tx_mod_start_i,
  input wire tx_end_i,
  output reg cal_busy_o,
  output reg cal_bass_sel_o,
  output reg [3:0] cal_test_code_o,
  output reg [3:0] bass_cut_trim_o,
  output reg [3:0] treble_cut_trim_o,
  output reg [2:0] bass_cut_corner_sel_o,
  output reg [2:0] treble_cut_corner_sel_o,
  output reg stage_skip_first_o,
  output reg stage_skip_second_o,
  output reg [4:0] link_group_o,
  output reg ac_store_o,
  output reg ac_hold_o,
  output reg [1:0] ac_tau_sel_o
);

  localparam S_IDLE = 3'b001;
  localparam S_SET = 3'b010;
  localparam S_WAIT = 3'b100;
  localparam A_IDLE = 3'b001;
  localparam A_HOLD = 3'b010;
  localparam A_RAMP = 3'b100;

  reg [7:0] filt_q;
  reg [7:0] misc2_q;
  reg [3:0] bass_trim_q;
  reg [3:0] treb_trim_q;
  reg [2:0] cal_st_q;
  reg [2:0] cal_step_q;
  reg [3:0] sar_q;
  reg [3:0] bass_res_q;
  reg [19:0] cal_cnt_q;
  reg [2:0] cmp_sync_q;
  reg cmp_q;
  reg [2:0] ac_st_q;
  reg [15:0] ac_cnt_q;
  reg [1:0] ac_idx_q;
  wire cal_cmd;
  wire nudge_ok;
  wire [3:0] bit_mask;

  // ***************************************************
  // Comparator synchroniser
  // ***************************************************

  // Third stage must agree with second before a level change counts
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_sync_q <= 3'h0;
      cmp_q <= 1'b0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[1:0], cal_cmp_i};
      if (cmp_sync_q[1] == cmp_sync_q[2]) begin
        cmp_q <= cmp_sync_q[2];
      end
    end
  end

  // ***************************************************
  // Register file
  // ***************************************************

  // Host writes to the settings registers
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filt_q <= `RFC_FILT_RST;
      misc2_q <= `RFC_MISC2_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `RFC_ADDR_FILT) begin
        filt_q <= reg_wdata_i;
      end
      if (reg_addr_i == `RFC_ADDR_MISC2) begin
        misc2_q <= reg_wdata_i;
      end
    end
  end

  // Read data registered; unmapped addresses and other pages read zero
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RFC_ADDR_FILT: reg_rdata_o <= filt_q;
        `RFC_ADDR_MISC2: reg_rdata_o <= misc2_q;
        `RFC_ADDR_STAT: begin
          if (misc2_q[`RFC_PAGE_MSB:`RFC_PAGE_LSB] == `RFC_PAGE_TRIM) begin
            reg_rdata_o <= {treb_trim_q, bass_trim_q}; // [RULE4]
          end else begin
            reg_rdata_o <= 8'h00;
          end
        end
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ***************************************************
  // Filter setting decode
  // ***************************************************

  // Corner selects, bypasses and link-frequency group, all registered
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bass_cut_corner_sel_o <= 3'h0;
      treble_cut_corner_sel_o <= 3'h0;
      stage_skip_first_o <= 1'b0;
      stage_skip_second_o <= 1'b0;
      link_group_o <= 5'h00;
    end else begin
      bass_cut_corner_sel_o <= filt_q[`RFC_BASS_MSB:`RFC_BASS_LSB]; // [RULE7]
      treble_cut_corner_sel_o <= filt_q[`RFC_TREB_MSB:`RFC_TREB_LSB]; // [RULE7]
      stage_skip_first_o <= filt_q[`RFC_SKIP1_BIT]; // [RULE8]
      stage_skip_second_o <= filt_q[`RFC_SKIP2_BIT]; // [RULE8]
      // Bit0 640k, bit1 320k, bit2 250k, bit3 160k, bit4 40k; other codes none
      case (filt_q) // [RULE12]
        8'h00, 8'h07: link_group_o <= 5'h01;
        8'h20, 8'h27: link_group_o <= 5'h02;
        8'h30, 8'h37: link_group_o <= 5'h04;
        8'h3B, 8'h3F: link_group_o <= 5'h08;
        8'hFF: link_group_o <= 5'h10;
        default: link_group_o <= 5'h00;
      endcase
    end
  end

  // ***************************************************
  // Calibration sequencer and trim values
  // ***************************************************

  assign cal_cmd = cmd_valid_i && (cmd_code_i == `RFC_CMD_CAL);
  assign nudge_ok = cmd_valid_i && misc2_q[`RFC_NUDGE_BIT] && (cal_st_q == S_IDLE);
  assign bit_mask = 4'h8 >> cal_step_q[1:0];

  // Binary search per trim, 4 steps each, bass first; a high comparator means
  // the trial code is too large. Each step settles a fixed time, so the whole
  // run is 8 steps plus a few cycles, well within the limit.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_st_q <= S_IDLE;
      cal_step_q <= 3'h0;
      sar_q <= 4'h0;
      bass_res_q <= 4'h0;
      cal_cnt_q <= 20'h00000;
      bass_trim_q <= `RFC_TRIM_RST;
      treb_trim_q <= `RFC_TRIM_RST;
    end else begin
      case (cal_st_q)
        S_IDLE: begin
          if (cal_cmd) begin
            cal_st_q <= S_SET; // [RULE1]
            cal_step_q <= 3'h0;
            sar_q <= 4'h0;
          end else if (nudge_ok && cmd_code_i == `RFC_CMD_DEC) begin
            // Saturate rather than wrap: a wrap would jump across the range
            if (bass_trim_q != 4'h0) bass_trim_q <= bass_trim_q - 4'h1; // [RULE5] [RULE6]
            if (treb_trim_q != 4'h0) treb_trim_q <= treb_trim_q - 4'h1; // [RULE5] [RULE6]
          end else if (nudge_ok && cmd_code_i == `RFC_CMD_INC) begin
            if (bass_trim_q != 4'hF) bass_trim_q <= bass_trim_q + 4'h1; // [RULE5] [RULE6]
            if (treb_trim_q != 4'hF) treb_trim_q <= treb_trim_q + 4'h1; // [RULE5] [RULE6]
          end
        end
        S_SET: begin
          sar_q <= sar_q | bit_mask;
          cal_cnt_q <= CAL_STEP_CYC[19:0] - 20'h1; // [RULE2]
          cal_st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (cal_cnt_q != 20'h0) begin
            cal_cnt_q <= cal_cnt_q - 20'h1;
          end else begin
            cal_st_q <= S_SET;
            cal_step_q <= cal_step_q + 3'h1;
            if (cal_step_q == 3'h3) begin
              bass_res_q <= cmp_q ? (sar_q & ~bit_mask) : sar_q;
              sar_q <= 4'h0;
            end else if (cal_step_q == 3'h7) begin
              // Both results applied together only at completion
              bass_trim_q <= bass_res_q; // [RULE14]
              treb_trim_q <= cmp_q ? (sar_q & ~bit_mask) : sar_q; // [RULE14]
              cal_st_q <= S_IDLE;
            end else if (cmp_q) begin
              sar_q <= sar_q & ~bit_mask;
            end
          end
        end
        default: cal_st_q <= S_IDLE;
      endcase
    end
  end

  // Analogue-facing calibration and trim outputs
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_busy_o <= 1'b0;
      cal_bass_sel_o <= 1'b0;
      cal_test_code_o <= 4'h0;
      bass_cut_trim_o <= `RFC_TRIM_RST;
      treble_cut_trim_o <= `RFC_TRIM_RST;
    end else begin
      cal_busy_o <= (cal_st_q != S_IDLE);
      cal_bass_sel_o <= (cal_st_q != S_IDLE) && !cal_step_q[2];
      cal_test_code_o <= sar_q;
      bass_cut_trim_o <= bass_trim_q; // [RULE6]
      treble_cut_trim_o <= treb_trim_q; // [RULE6]
    end
  end

  // ***************************************************
  // Fast AC coupling
  // ***************************************************

  // Store strobe at modulation start; after TX, step the time constant from
  // fastest (0) to slowest so the path settles before the decoder listens
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ac_st_q <= A_IDLE;
      ac_cnt_q <= 16'h0000;
      ac_idx_q <= 2'h0;
      ac_store_o <= 1'b0;
      ac_hold_o <= 1'b0;
      ac_tau_sel_o <= 2'h3;
    end else begin
      ac_store_o <= 1'b0;
      case (ac_st_q)
        A_IDLE: begin
          if (tx_mod_start_i) begin
            ac_store_o <= 1'b1; // [RULE13]
            ac_hold_o <= 1'b1; // [RULE13]
            ac_st_q <= A_HOLD;
          end
        end
        A_HOLD: begin
          if (tx_end_i) begin
            ac_hold_o <= 1'b0;
            ac_idx_q <= 2'h0;
            ac_tau_sel_o <= 2'h0; // [RULE13]
            ac_cnt_q <= AC_STEP_CYC[15:0] - 16'h1;
            ac_st_q <= A_RAMP;
          end
        end
        A_RAMP: begin
          if (tx_mod_start_i) begin
            ac_store_o <= 1'b1;
            ac_hold_o <= 1'b1;
            ac_tau_sel_o <= 2'h3;
            ac_st_q <= A_HOLD;
          end else if (ac_cnt_q != 16'h0) begin
            ac_cnt_q <= ac_cnt_q - 16'h1;
          end else if (ac_idx_q == AC_STEPS[1:0] - 2'h1) begin
            ac_tau_sel_o <= 2'h3;
            ac_st_q <= A_IDLE;
          end else begin
            ac_idx_q <= ac_idx_q + 2'h1;
            ac_tau_sel_o <= ac_idx_q + 2'h1; // [RULE13]
            ac_cnt_q <= AC_STEP_CYC[15:0] - 16'h1;
          end
        end
        default: ac_st_q <= A_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/rfc_rx_filter_ctrl_props.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********
// Filter control checks
// ********
module rfc_rx_filter_ctrl_props #(
  parameter CAL_STEP_CYC = 8
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire reg_wr_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_code_i,
  input wire tx_mod_start_i,
  input wire tx_end_i,
  input wire cal_busy_o,
  input wire [3:0] bass_cut_trim_o,
  input wire [3:0] treble_cut_trim_o,
  input wire [2:0] bass_cut_corner_sel_o,
  input wire [2:0] treble_cut_corner_sel_o,
  input wire stage_skip_first_o,
  input wire stage_skip_second_o,
  input wire [4:0] link_group_o,
  input wire ac_store_o,
  input wire ac_hold_o,
  input wire [1:0] ac_tau_sel_o
);
  localparam int CAL_MAX = 8 * (CAL_STEP_CYC + 1) + 4;
  logic nudge_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the nudge enable, since that bit is not on a port
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nudge_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 6'h0E) begin
      nudge_q <= reg_wdata_i[7];
    end
  end
  // Expected link group of a filter code
  function automatic logic [4:0] grp(input logic [7:0] w);
    // Only the listed codes name a group; every other code maps to none
    return (w == 8'h00 || w == 8'h07) ? 5'h01 : (w == 8'h20 || w == 8'h27) ? 5'h02 :
      (w == 8'h30 || w == 8'h37) ? 5'h04 : (w == 8'h3B || w == 8'h3F) ? 5'h08 :
      (w == 8'hFF) ? 5'h10 : 5'h00;
  endfunction
  property p_cal_start;
    cmd_valid_i && cmd_code_i == 8'h88 && !cal_busy_o |-> ##[1:2] cal_busy_o;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("cal start");
  property p_cal_end;
    $rose(cal_busy_o) |-> ##[8:CAL_MAX] !cal_busy_o;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("cal length");
  property p_trim_keep;
    cal_busy_o && $past(cal_busy_o) |-> $stable(bass_cut_trim_o) && $stable(treble_cut_trim_o);
  endproperty
  a_trim_keep: assert property (p_trim_keep) else $error("trim moved in cal");
  property p_nudge_off;
    cmd_valid_i && (cmd_code_i == 8'h89 || cmd_code_i == 8'h8A) && !nudge_q && !cal_busy_o
      |-> ##1 $stable(treble_cut_trim_o) [*2];
  endproperty
  a_nudge_off: assert property (p_nudge_off) else $error("nudge not refused");
  property p_nudge_dec;
    cmd_valid_i && cmd_code_i == 8'h89 && nudge_q && !cal_busy_o && bass_cut_trim_o != 4'h0
      |-> ##2 bass_cut_trim_o == $past(bass_cut_trim_o, 2) - 4'h1;
  endproperty
  a_nudge_dec: assert property (p_nudge_dec) else $error("nudge step");
  property p_fields;
    reg_wr_i && reg_addr_i == 6'h09 |-> ##2 {stage_skip_second_o, stage_skip_first_o,
      treble_cut_corner_sel_o, bass_cut_corner_sel_o} == $past(reg_wdata_i, 2);
  endproperty
  a_fields: assert property (p_fields) else $error("filter fields");
  property p_group;
    reg_wr_i && reg_addr_i == 6'h09 |-> ##2 link_group_o == grp($past(reg_wdata_i, 2));
  endproperty
  a_group: assert property (p_group) else $error("link group");
  property p_ac_store;
    tx_mod_start_i && !ac_hold_o |=> ac_store_o && ac_hold_o;
  endproperty
  a_ac_store: assert property (p_ac_store) else $error("dc store");
  property p_ac_tau;
    tx_end_i && ac_hold_o |=> !ac_hold_o && ac_tau_sel_o == 2'h0;
  endproperty
  a_ac_tau: assert property (p_ac_tau) else $error("tau ramp start");
  c_cal: cover property ($fell(cal_busy_o));
  c_nudge: cover property (cmd_valid_i && cmd_code_i == 8'h89 && nudge_q);
  c_ramp: cover property (tx_end_i && ac_hold_o);
endmodule
bind rfc_rx_filter_ctrl rfc_rx_filter_ctrl_props #(.CAL_STEP_CYC(CAL_STEP_CYC)) i_props (.*);
`default_nettype wire

// ==== tb/rfc_cal_cell.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********
// Analogue calibration cell
// ********
module rfc_cal_cell #(
  parameter logic [3:0] BASS_TGT = 4'h6,
  parameter logic [3:0] TREB_TGT = 4'hA
) (
  input wire logic [3:0] test_code_i,
  input wire logic bass_sel_i,
  output logic cmp_o
);
  // Trips when the trial overshoots the spread of the part
  assign cmp_o = test_code_i > (bass_sel_i ? BASS_TGT : TREB_TGT);
endmodule
`default_nettype wire

// ==== tb/rfc_rx_filter_ctrl_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********
// Filter control bench
// ********
module rfc_rx_filter_ctrl_bench;
  localparam int AC = 6;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic tx_mod_start_i = 1'b0;
  logic tx_end_i = 1'b0;
  wire logic cal_cmp_i, cal_busy_o, cal_bass_sel_o, stage_skip_first_o, stage_skip_second_o;
  wire logic ac_store_o, ac_hold_o;
  wire logic [7:0] reg_rdata_o;
  wire logic [3:0] cal_test_code_o, bass_cut_trim_o, treble_cut_trim_o;
  wire logic [2:0] bass_cut_corner_sel_o, treble_cut_corner_sel_o;
  wire logic [4:0] link_group_o;
  wire logic [1:0] ac_tau_sel_o;
  int failures = 0;
  int checks = 0;
  int seed = 32'h05dc;
  int n = 0;
  logic rd_s = 1'b0;
  logic rd_s2 = 1'b0;
  logic [7:0] v;
  logic [7:0] q[$];
  // Proposed host codes first, then the remaining listed group codes
  logic [7:0] codes [13] = '{8'hFF, 8'h24, 8'h34, 8'hBF, 8'h3F, 8'h04, 8'h07, 8'h27, 8'h3B,
    8'h00, 8'h20, 8'h30, 8'h37};
  logic [4:0] grps [13] = '{5'h10, 5'h00, 5'h00, 5'h00, 5'h08, 5'h00, 5'h01, 5'h02, 5'h08,
    5'h01, 5'h02, 5'h04, 5'h04};
  rfc_rx_filter_ctrl #(.CAL_STEP_CYC(8), .AC_STEP_CYC(AC), .AC_STEPS(4)) i_dut (.*);
  rfc_cal_cell i_cell (.test_code_i(cal_test_code_o), .bass_sel_i(cal_bass_sel_o),
    .cmp_o(cal_cmp_i));
  always #2 clk_sys_i = ~clk_sys_i;
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register access; a read notes its expected value for the monitor
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    if (!w) q.push_back(d);
    @(posedge clk_sys_i);
    #1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
  endtask
  // Idle edges after a command let the trims settle before a read
  task automatic cmd(input logic [7:0] c);
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic pulse(input logic s);
    @(posedge clk_sys_i);
    #1;
    tx_mod_start_i = s;
    tx_end_i = !s;
    @(posedge clk_sys_i);
    #1;
    tx_mod_start_i = 1'b0;
    tx_end_i = 1'b0;
  endtask
  function automatic logic cond(input int k);
    return k == 0 ? cal_busy_o : k == 1 ? !cal_busy_o : ac_tau_sel_o == 2'h3;
  endfunction
  task automatic await(input int k);
    n = 0;
    while (cond(k) !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n == 200) begin
      failures++;
      $display("mismatch wait expected done seen timeout");
      end_sim();
    end
  endtask
  // Read data is valid one cycle after the strobe; compare mid-cycle
  always @(posedge clk_sys_i) begin
    rd_s <= reg_rd_i;
    rd_s2 <= rd_s;
  end
  always @(negedge clk_sys_i) begin
    if (rd_s2) begin
      chk("read", q.pop_front(), reg_rdata_o);
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    bus(1, 6'h0E, 8'h20);
    bus(0, 6'h2C, 8'h88); // Trim page at reset
    bus(0, 6'h15, 8'h00);
    $display("test reset done");
    cmd(8'h88); // Calibrate after power-up
    await(0);
    await(1);
    chk("cal_len", 8'h01, 8'(n > 60 && n < 76)); // Bounded run
    bus(0, 6'h2C, 8'hA6); // Result fields
    chk("trim_o", 8'hA6, {treble_cut_trim_o, bass_cut_trim_o}); // Applied at end
    cmd(8'h89);
    bus(0, 6'h2C, 8'hA6); // Nudge locked
    bus(1, 6'h0E, 8'hA0);
    cmd(8'h89);
    bus(0, 6'h2C, 8'h95); // Both trims down
    chk("trim_o", 8'h95, {treble_cut_trim_o, bass_cut_trim_o}); // Applied trims
    n = $random(seed) & 3;
    repeat (n + 1) cmd(8'h8A);
    bus(0, 6'h2C, 8'h11 * 8'(n + 1) + 8'h95); // Both trims up
    bus(1, 6'h0E, 8'h00);
    bus(0, 6'h2C, 8'h00); // Other page hides trims
    $display("test trim done");
    for (int i = 0; i < 17; i++) begin
      v = i < 13 ? codes[i] : 8'($random(seed));
      bus(1, 6'h09, v); // Host filter codes
      bus(1, 6'h15, ~v);
      bus(0, 6'h09, v); // Readback
      chk("sels", v, {stage_skip_second_o, stage_skip_first_o, treble_cut_corner_sel_o,
        bass_cut_corner_sel_o}); // Field split
      if (i < 13) begin
        chk("group", 8'(grps[i]), 8'(link_group_o)); // Link group
      end
    end
    $display("test filter done");
    pulse(1'b1);
    chk("store", 8'h03, {6'h00, ac_store_o, ac_hold_o}); // DC store
    pulse(1'b0);
    chk("tau", 8'h00, {5'h00, ac_hold_o, ac_tau_sel_o}); // Fast start
    await(2);
    chk("ramp", 8'h01, 8'(n >= 3 * AC - 4 && n <= 3 * AC + 4)); // Ramp pace
    $display("test coupling done");
    end_sim();
  end
endmodule
`default_nettype wire
